// file: hdl/mcb_pkg.sv
package mcb_pkg;
    // Bank placement: one 4 KB window at a fixed base
    localparam logic [31:0] MCB_BASE_ADDR = 32'h4002_0000;
    localparam logic [31:0] MCB_BANK_MASK = 32'hFFFF_F000;
    localparam int MCB_OFF_W = 12;

    // Register byte offsets within the bank
    localparam logic [11:0] MCB_OFF_CHIP_INFORMATION = 12'h000;
    localparam logic [11:0] MCB_OFF_UID_LOW = 12'h004;
    localparam logic [11:0] MCB_OFF_UID_HIGH = 12'h008;
    localparam logic [11:0] MCB_OFF_SI_REV = 12'h00C;
    localparam logic [11:0] MCB_OFF_SUPPLY_SEL = 12'h010;
    localparam logic [11:0] MCB_OFF_SUPPLY_STATE = 12'h014;
    localparam logic [11:0] MCB_OFF_REF_EN = 12'h0FC;
    localparam logic [11:0] MCB_OFF_SLEEP_PD = 12'h140;

    // AXI4-Lite response codes
    localparam logic [1:0] MCB_RESP_OKAY = 2'h0;
    localparam logic [1:0] MCB_RESP_SLVERR = 2'h2;
    localparam logic [1:0] MCB_RESP_DECERR = 2'h3;

    // Chip information field codes
    localparam logic [3:0] MCB_FLASH_256K = 4'h3;
    localparam logic [3:0] MCB_FLASH_512K = 4'h4;
    localparam logic [3:0] MCB_SRAM_32K = 4'h0;
    localparam logic [3:0] MCB_SRAM_64K = 4'h1;
    localparam logic [3:0] MCB_REV_MAJOR_RST = 4'h1;
    localparam logic [3:0] MCB_REV_MINOR_RST = 4'h1;
    localparam logic [1:0] MCB_PKG_BGA = 2'h2;
    localparam logic [1:0] MCB_PKG_CSP = 2'h3;
    localparam logic [1:0] MCB_PKG_RST = 2'h1;
    localparam logic [2:0] MCB_PINS_41 = 3'h1;
    localparam logic [2:0] MCB_PINS_64 = 3'h1;
    localparam logic [1:0] MCB_TEMP_COMMERCIAL = 2'h0;
    localparam logic [1:0] MCB_TEMP_RST = 2'h1;
    localparam logic MCB_PROTOTYPE_PART = 1'h0;
    localparam logic MCB_QUALIFIED_PART = 1'h1;

    // Writable control reset values
    localparam logic [1:0] MCB_SUPPLY_SEL_RST = 2'h0;
    localparam logic MCB_REF_EN_RST = 1'h0;
    localparam logic [7:0] MCB_SLEEP_PD_RST = 8'h00;

    // Pin synchroniser depth and SRAM segment count
    localparam int MCB_SYNC_STAGES = 2;
    localparam int MCB_SEGMENTS = 8;

    // Chip information word layout, msb first
    typedef struct packed {
        logic [7:0] dev_class;
        logic [3:0] flash_size;
        logic [3:0] sram_size;
        logic [3:0] revision_major;
        logic [3:0] revision_minor;
        logic [1:0] package_type;
        logic [2:0] pin_count;
        logic [1:0] temp_range;
        logic qualified_flag;
    } mcb_chip_information_s;

    // Supply select and state layout: core in bit 1, memory in bit 0
    typedef struct packed {
        logic core;
        logic mem;
    } mcb_supply_s;

    // AXI4-Lite master to slave
    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } mcb_axi_req_s;

    // AXI4-Lite slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } mcb_axi_rsp_s;

    // Complete state of the bank
    typedef struct packed {
        logic aw_held;
        logic [31:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        mcb_supply_s supply_sel;
        logic ref_on;
        logic [7:0] sleep_pd;
        logic [7:0] seg_off;
    } mcb_bank_state_s;

    // State of one supply hand-over tracker
    typedef struct packed {
        logic [MCB_SYNC_STAGES-1:0] sync;
        logic active;
    } mcb_track_state_s;
endpackage : mcb_pkg

// file: hdl/mcb_supply_track.sv
// Follows one regulator hand-over; status rises on enable with the converter's report, falls only when the report drops
module mcb_supply_track
    import mcb_pkg::*;
#(
    parameter int SYNC_STAGES = MCB_SYNC_STAGES
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic enable_i,
    input wire logic ready_i,
    output logic active_o
);
    mcb_track_state_s st_r;
    mcb_track_state_s st_nxt;
    logic ready_s;

    // Last stage only; the first stage feeds nothing but the second
    assign ready_s = st_r.sync[SYNC_STAGES-1];

    // Shift the pin in, then decide the source
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync = {st_r.sync[SYNC_STAGES-2:0], ready_i};
        // Buck shown only once it reports feeding; held until it stops
        st_nxt.active = ready_s & (enable_i | st_r.active);
    end

    // Single state register
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign active_o = st_r.active;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    // Never claim the buck before it was enabled and reported ready
    AST_HANDOVER_RISE: assert property (
        $rose(active_o) |-> $past(enable_i) && $past(ready_i, 3) && $past(ready_i, 2)
    ) else $error("converter shown active without enable and report");

    // Losing the report drops the status within the sync delay
    AST_HANDOVER_FALL: assert property (
        !ready_i [*3] |=> !active_o
    ) else $error("converter still shown active after report fell");
endmodule : mcb_supply_track

// file: hdl/mcb_misc_control_bank.sv
// Contract
// - Bank decoded at fixed base, word offsets
// - Flash size field bits 23:20, read-only
// - SRAM size field bits 19:16, read-only
// - Major/minor revision and class fields read-only
// - Package type field bits 7:6
// - Pin count field bits 5:3
// - Temperature range field bits 2:1
// - Bit 0 flags qualified versus prototype
// - Select bit 1 enables core buck
// - Select bit 0 enables memory buck
// - State bit 1 shows core domain source
// - State bit 0 shows memory domain source
// - Reference enable bit 0, resets off
// - Set bits power SRAM segments off sleeping
module mcb_misc_control_bank
    import mcb_pkg::*;
#(
    parameter logic [31:0] BASE_ADDR = MCB_BASE_ADDR,
    parameter logic [3:0] FLASH_SIZE_CODE = MCB_FLASH_512K,
    parameter logic [3:0] SRAM_SIZE_CODE = MCB_SRAM_64K,
    parameter logic [3:0] REVISION_MAJOR = MCB_REV_MAJOR_RST,
    parameter logic [3:0] REVISION_MINOR = MCB_REV_MINOR_RST,
    parameter logic [1:0] PACKAGE_CODE = MCB_PKG_RST,
    parameter logic [2:0] PIN_COUNT_CODE = MCB_PINS_41,
    parameter logic [1:0] TEMP_RANGE_CODE = MCB_TEMP_RST,
    parameter logic QUALIFIED = MCB_QUALIFIED_PART,
    // Arbitrary value
    parameter logic [7:0] DEVICE_CLASS = 8'h2C,
    // Arbitrary value
    parameter logic [31:0] UNIQUE_ID_LOW = 32'h1357_9BDF,
    // Arbitrary value
    parameter logic [31:0] UNIQUE_ID_HIGH = 32'h2468_ACE0,
    // Arbitrary value
    parameter logic [7:0] SILICON_REVISION = 8'h21
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire mcb_axi_req_s axi_req_i,
    output mcb_axi_rsp_s axi_rsp_o,
    input wire logic core_converter_ready_i,
    input wire logic memory_converter_ready_i,
    input wire logic deep_sleep_i,
    output logic core_converter_enable_o,
    output logic memory_converter_enable_o,
    output logic core_converter_active_o,
    output logic memory_converter_active_o,
    output logic reference_on_o,
    output logic [MCB_SEGMENTS-1:0] off_during_deep_sleep_o,
    output logic [MCB_SEGMENTS-1:0] sram_segment_off_o
);
    // Whole bank state and its next value
    mcb_bank_state_s st_r;
    mcb_bank_state_s st_nxt;

    // Handshake terms on the three request channels and the write commit
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wr_commit;

    // Decoded read address
    logic ar_in_bank;
    logic [MCB_OFF_W-1:0] ar_off;

    // Decoded write address
    logic aw_in_bank;
    logic [MCB_OFF_W-1:0] aw_off;

    // Live read-only views
    mcb_chip_information_s chip_information;
    mcb_supply_s supply_state;
    logic core_active;
    logic mem_active;

    // Fixed chip information word
    assign chip_information = '{
        dev_class: DEVICE_CLASS,
        flash_size: FLASH_SIZE_CODE,
        sram_size: SRAM_SIZE_CODE,
        revision_major: REVISION_MAJOR,
        revision_minor: REVISION_MINOR,
        package_type: PACKAGE_CODE,
        pin_count: PIN_COUNT_CODE,
        temp_range: TEMP_RANGE_CODE,
        qualified_flag: QUALIFIED
    };

    // Core domain hand-over tracker
    mcb_supply_track #(
        .SYNC_STAGES(MCB_SYNC_STAGES)
    ) u_core_track (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .enable_i(st_r.supply_sel.core),
        .ready_i(core_converter_ready_i),
        .active_o(core_active)
    );

    // Memory domain hand-over tracker
    mcb_supply_track #(
        .SYNC_STAGES(MCB_SYNC_STAGES)
    ) u_mem_track (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .enable_i(st_r.supply_sel.mem),
        .ready_i(memory_converter_ready_i),
        .active_o(mem_active)
    );

    // Status comes from the trackers, not the select bits
    assign supply_state = '{core: core_active, mem: mem_active};

    // Ready while the holding slot is free; no buffering beyond one slot
    assign aw_take = axi_req_i.awvalid & ~st_r.aw_held;
    assign w_take = axi_req_i.wvalid & ~st_r.w_held;
    assign ar_take = axi_req_i.arvalid & ~st_r.rvalid;

    // Write completes once both halves are in and the last answer is gone
    assign wr_commit = st_r.aw_held & st_r.w_held & ~st_r.bvalid;

    // Base match on the upper address bits
    assign ar_in_bank = (axi_req_i.araddr & MCB_BANK_MASK) == BASE_ADDR;
    assign aw_in_bank = (st_r.aw_addr & MCB_BANK_MASK) == BASE_ADDR;
    assign ar_off = axi_req_i.araddr[MCB_OFF_W-1:0];
    assign aw_off = st_r.aw_addr[MCB_OFF_W-1:0];

    // Next-state logic for the bus slave and the control registers
    always_comb begin
        logic [31:0] rd_word;
        logic [1:0] rd_resp;
        logic [1:0] wr_resp;
        rd_word = '0;
        rd_resp = MCB_RESP_OKAY;
        wr_resp = MCB_RESP_OKAY;
        st_nxt = st_r;

        // Read decode; unused upper bits stay zero
        if (!ar_in_bank) begin
            rd_resp = MCB_RESP_DECERR;
        end else if (ar_off == MCB_OFF_CHIP_INFORMATION) begin
            rd_word = chip_information;
        end else if (ar_off == MCB_OFF_UID_LOW) begin
            rd_word = UNIQUE_ID_LOW;
        end else if (ar_off == MCB_OFF_UID_HIGH) begin
            rd_word = UNIQUE_ID_HIGH;
        end else if (ar_off == MCB_OFF_SI_REV) begin
            rd_word = {24'h00_0000, SILICON_REVISION};
        end else if (ar_off == MCB_OFF_SUPPLY_SEL) begin
            rd_word = {30'h0000_0000, st_r.supply_sel};
        end else if (ar_off == MCB_OFF_SUPPLY_STATE) begin
            // Actual source of each domain
            rd_word = {30'h0000_0000, supply_state};
        end else if (ar_off == MCB_OFF_REF_EN) begin
            rd_word = {31'h0000_0000, st_r.ref_on};
        end else if (ar_off == MCB_OFF_SLEEP_PD) begin
            rd_word = {24'h00_0000, st_r.sleep_pd};
        end else begin
            // Hole inside the bank: refused, data zero
            rd_resp = MCB_RESP_SLVERR;
        end

        // Address half of a write
        if (aw_take) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = axi_req_i.awaddr;
        end

        // Data half of a write
        if (w_take) begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = axi_req_i.wdata;
            st_nxt.w_strb = axi_req_i.wstrb;
        end

        // Write answer leaves on bready
        if (st_r.bvalid && axi_req_i.bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Write decode; every writable bit sits in byte lane 0
        if (!aw_in_bank) begin
            wr_resp = MCB_RESP_DECERR;
        end else if (aw_off == MCB_OFF_CHIP_INFORMATION || aw_off == MCB_OFF_UID_LOW ||
                     aw_off == MCB_OFF_UID_HIGH || aw_off == MCB_OFF_SI_REV ||
                     aw_off == MCB_OFF_SUPPLY_STATE) begin
            // Read-only words accept and drop the data
            wr_resp = MCB_RESP_OKAY;
        end else if (aw_off == MCB_OFF_SUPPLY_SEL || aw_off == MCB_OFF_REF_EN ||
                     aw_off == MCB_OFF_SLEEP_PD) begin
            wr_resp = MCB_RESP_OKAY;
        end else begin
            wr_resp = MCB_RESP_SLVERR;
        end

        // Commit: update control bits, raise the answer
        if (wr_commit) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = wr_resp;
            if (aw_in_bank && st_r.w_strb[0]) begin
                if (aw_off == MCB_OFF_SUPPLY_SEL) begin
                    // Only bits 1:0 land; the rest are dropped
                    st_nxt.supply_sel = st_r.w_data[1:0];
                end else if (aw_off == MCB_OFF_REF_EN) begin
                    st_nxt.ref_on = st_r.w_data[0];
                end else if (aw_off == MCB_OFF_SLEEP_PD) begin
                    st_nxt.sleep_pd = st_r.w_data[7:0];
                end
            end
        end

        // Read answer leaves on rready
        if (st_r.rvalid && axi_req_i.rready) begin
            st_nxt.rvalid = 1'b0;
        end

        // Read taken: data registered for the next cycle
        if (ar_take) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_word;
            st_nxt.rresp = rd_resp;
        end

        // Segment cut only while asleep; contents are lost then
        st_nxt.seg_off = st_r.sleep_pd & {MCB_SEGMENTS{deep_sleep_i}};
    end

    // Single state register; all controls clear on reset
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            st_r <= '0;
            st_r.supply_sel <= MCB_SUPPLY_SEL_RST;
            st_r.ref_on <= MCB_REF_EN_RST;
            st_r.sleep_pd <= MCB_SLEEP_PD_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Bus answers; readies are combinational from the holding slots
    assign axi_rsp_o.awready = ~st_r.aw_held;
    assign axi_rsp_o.wready = ~st_r.w_held;
    assign axi_rsp_o.bvalid = st_r.bvalid;
    assign axi_rsp_o.bresp = st_r.bresp;
    assign axi_rsp_o.arready = ~st_r.rvalid;
    assign axi_rsp_o.rvalid = st_r.rvalid;
    assign axi_rsp_o.rdata = st_r.rdata;
    assign axi_rsp_o.rresp = st_r.rresp;

    // Controls out to the supply and memory macros
    assign core_converter_enable_o = st_r.supply_sel.core;
    assign memory_converter_enable_o = st_r.supply_sel.mem;
    assign core_converter_active_o = core_active;
    assign memory_converter_active_o = mem_active;
    assign reference_on_o = st_r.ref_on;
    assign off_during_deep_sleep_o = st_r.sleep_pd;
    assign sram_segment_off_o = st_r.seg_off;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    // Reads outside the window are refused with a decode error
    AST_BASE_DECODE: assert property (
        ar_take && !ar_in_bank |=> axi_rsp_o.rvalid && axi_rsp_o.rresp == MCB_RESP_DECERR
    ) else $error("read outside bank not refused");

    // Flash code read back from the information word
    AST_FLASH_FIELD: assert property (
        ar_take && ar_in_bank && ar_off == MCB_OFF_CHIP_INFORMATION
        |=> axi_rsp_o.rdata[23:20] == FLASH_SIZE_CODE
    ) else $error("flash size field wrong");

    // SRAM code read back
    AST_SRAM_FIELD: assert property (
        ar_take && ar_in_bank && ar_off == MCB_OFF_CHIP_INFORMATION
        |=> axi_rsp_o.rdata[19:16] == SRAM_SIZE_CODE
    ) else $error("sram size field wrong");

    // Revision numbers and class in place
    AST_REV_FIELDS: assert property (
        ar_take && ar_in_bank && ar_off == MCB_OFF_CHIP_INFORMATION
        |=> axi_rsp_o.rdata[15:12] == REVISION_MAJOR && axi_rsp_o.rdata[11:8] == REVISION_MINOR
            && axi_rsp_o.rdata[31:24] == DEVICE_CLASS
    ) else $error("revision or class field wrong");

    // Package, pins, temperature and qualification in place
    AST_PKG_FIELD: assert property (
        ar_take && ar_in_bank && ar_off == MCB_OFF_CHIP_INFORMATION
        |=> axi_rsp_o.rdata[7:6] == PACKAGE_CODE
    ) else $error("package field wrong");

    AST_PINS_FIELD: assert property (
        ar_take && ar_in_bank && ar_off == MCB_OFF_CHIP_INFORMATION
        |=> axi_rsp_o.rdata[5:3] == PIN_COUNT_CODE
    ) else $error("pin count field wrong");

    AST_TEMP_FIELD: assert property (
        ar_take && ar_in_bank && ar_off == MCB_OFF_CHIP_INFORMATION
        |=> axi_rsp_o.rdata[2:1] == TEMP_RANGE_CODE
    ) else $error("temperature field wrong");

    AST_QUALIFIED_FIELD: assert property (
        ar_take && ar_in_bank && ar_off == MCB_OFF_CHIP_INFORMATION
        |=> axi_rsp_o.rdata[0] == QUALIFIED
    ) else $error("qualified flag wrong");

    // A committed select write reaches the converter enables
    AST_CORE_SEL: assert property (
        wr_commit && aw_in_bank && aw_off == MCB_OFF_SUPPLY_SEL && st_r.w_strb[0]
        |=> core_converter_enable_o == $past(st_r.w_data[1]) && axi_rsp_o.bvalid
    ) else $error("core enable did not follow write");

    AST_MEM_SEL: assert property (
        wr_commit && aw_in_bank && aw_off == MCB_OFF_SUPPLY_SEL && st_r.w_strb[0]
        |=> memory_converter_enable_o == $past(st_r.w_data[0])
    ) else $error("memory enable did not follow write");

    // State reads return the tracker outputs of the taking edge
    AST_CORE_STATE: assert property (
        ar_take && ar_in_bank && ar_off == MCB_OFF_SUPPLY_STATE
        |=> axi_rsp_o.rdata[1] == $past(core_active) && axi_rsp_o.rdata[31:2] == '0
    ) else $error("core state bit wrong");

    AST_MEM_STATE: assert property (
        ar_take && ar_in_bank && ar_off == MCB_OFF_SUPPLY_STATE
        |=> axi_rsp_o.rdata[0] == $past(mem_active)
    ) else $error("memory state bit wrong");

    // Reference enable follows its write
    AST_REF_ON: assert property (
        wr_commit && aw_in_bank && aw_off == MCB_OFF_REF_EN && st_r.w_strb[0]
        |=> reference_on_o == $past(st_r.w_data[0])
    ) else $error("reference enable did not follow write");

    // Segments cut exactly while asleep and selected
    AST_SLEEP_OFF: assert property (
        1'b1 |=> sram_segment_off_o == ($past(st_r.sleep_pd) & {MCB_SEGMENTS{$past(deep_sleep_i)}})
    ) else $error("segment power-down mismatch");

    // Reserved bits of the reference word read zero
    AST_RSVD_ZERO: assert property (
        ar_take && ar_in_bank && ar_off == MCB_OFF_REF_EN |=> axi_rsp_o.rdata[31:1] == '0
    ) else $error("reserved bits not zero");

    // Main scenarios
    COV_SELECT_WRITE: cover property (
        wr_commit && aw_in_bank && aw_off == MCB_OFF_SUPPLY_SEL
    );
    COV_STATE_READ: cover property (ar_take && ar_off == MCB_OFF_SUPPLY_STATE && core_active);
    COV_SLEEP_CUT: cover property (|sram_segment_off_o);
    COV_HOLE_READ: cover property (ar_take && ar_in_bank && ar_off == 12'h018);
endmodule : mcb_misc_control_bank

// file: testbench/testbench.sv
module testbench
    import mcb_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // One table row: bus access in, expected answer out
    typedef struct packed {
        logic [12:0] off;
        logic [31:0] wdata;
        logic [3:0] strb;
        logic [1:0] resp;
        logic [31:0] rdata;
        logic dchk;
    } mcb_tb_row_s;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    mcb_axi_req_s req = '0;
    mcb_axi_rsp_s rsp;
    logic core_rdy = 1'b0;
    logic mem_rdy = 1'b0;
    logic deep_sleep = 1'b0;
    logic core_en, mem_en, core_act, mem_act, ref_on;
    logic [MCB_SEGMENTS-1:0] pd_bits;
    logic [MCB_SEGMENTS-1:0] seg_off;
    int mismatches = 0;
    int checked = 0;
    logic [31:0] rd;
    logic [1:0] rs;

    // Default identity parameters; chip word 0x2C41114B follows from them
    mcb_tb_row_s rows [12] = '{
        '{MCB_OFF_CHIP_INFORMATION, 32'hFFFF_FFFF, 4'hF, MCB_RESP_OKAY, 32'h2C41_114B, 1'b1},
        '{MCB_OFF_UID_LOW, 32'h0000_0000, 4'hF, MCB_RESP_OKAY, 32'h1357_9BDF, 1'b1},
        '{MCB_OFF_UID_HIGH, 32'h0000_0000, 4'hF, MCB_RESP_OKAY, 32'h2468_ACE0, 1'b1},
        '{MCB_OFF_SI_REV, 32'hFFFF_FFFF, 4'hF, MCB_RESP_OKAY, 32'h0000_0021, 1'b1},
        '{MCB_OFF_SUPPLY_SEL, 32'hFFFF_FFFF, 4'hF, MCB_RESP_OKAY, 32'h0000_0003, 1'b1},
        '{MCB_OFF_SUPPLY_SEL, 32'h0000_0000, 4'hE, MCB_RESP_OKAY, 32'h0000_0003, 1'b1},
        '{MCB_OFF_SUPPLY_STATE, 32'hFFFF_FFFF, 4'hF, MCB_RESP_OKAY, 32'h0000_0000, 1'b1},
        '{MCB_OFF_REF_EN, 32'hFFFF_FFFF, 4'hF, MCB_RESP_OKAY, 32'h0000_0001, 1'b1},
        '{MCB_OFF_SLEEP_PD, 32'hFFFF_FFFF, 4'hF, MCB_RESP_OKAY, 32'h0000_00FF, 1'b1},
        '{MCB_OFF_SLEEP_PD, 32'h0000_0081, 4'h1, MCB_RESP_OKAY, 32'h0000_0081, 1'b1},
        '{13'h0018, 32'hFFFF_FFFF, 4'hF, MCB_RESP_SLVERR, 32'h0000_0000, 1'b1},
        '{13'h1000, 32'hFFFF_FFFF, 4'hF, MCB_RESP_DECERR, 32'h0000_0000, 1'b0}
    };

    mcb_misc_control_bank u_dut (
        .clk_sys_i(clk),
        .reset_n_i(reset_n),
        .axi_req_i(req),
        .axi_rsp_o(rsp),
        .core_converter_ready_i(core_rdy),
        .memory_converter_ready_i(mem_rdy),
        .deep_sleep_i(deep_sleep),
        .core_converter_enable_o(core_en),
        .memory_converter_enable_o(mem_en),
        .core_converter_active_o(core_act),
        .memory_converter_active_o(mem_act),
        .reference_on_o(ref_on),
        .off_during_deep_sleep_o(pd_bits),
        .sram_segment_off_o(seg_off)
    );

    // 125 MHz system clock
    initial begin
        forever #4 clk = ~clk;
    end

    // Compare any value, widened to a word
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // All control outputs packed into one word
    task automatic chk_ports(input logic [31:0] exp);
        chk({11'h0, core_en, mem_en, core_act, mem_act, ref_on, pd_bits, seg_off}, exp);
    endtask : chk_ports

    // Let edges pass, then step past the updates of the last one
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Write: address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [12:0] off, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        logic aw, w, got;
        aw = 1'b0;
        w = 1'b0;
        got = 1'b0;
        r = 2'h1;
        @(posedge clk);
        req.awaddr <= MCB_BASE_ADDR + 32'(off);
        req.wdata <= d;
        req.wstrb <= s;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        for (int n = 0; n < 50 && !got; n++) begin
            @(posedge clk);
            if (rsp.bvalid && aw && w) begin
                r = rsp.bresp;
                got = 1'b1;
                req.bready <= 1'b0;
            end
            if (!aw && rsp.awready) begin
                aw = 1'b1;
                req.awvalid <= 1'b0;
            end
            if (!w && rsp.wready) begin
                w = 1'b1;
                req.wvalid <= 1'b0;
            end
        end
        // A hung write is itself a mismatch
        if (!got) chk(32'h0, 32'h1);
    endtask : axi_wr

    // Read: address held until taken, data caught at the rvalid edge
    task automatic axi_rd(input logic [12:0] off, output logic [31:0] d, output logic [1:0] r);
        logic ar, got;
        ar = 1'b0;
        got = 1'b0;
        d = 32'h0;
        r = 2'h1;
        @(posedge clk);
        req.araddr <= MCB_BASE_ADDR + 32'(off);
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        for (int n = 0; n < 50 && !got; n++) begin
            @(posedge clk);
            if (rsp.rvalid && ar) begin
                d = rsp.rdata;
                r = rsp.rresp;
                got = 1'b1;
                req.rready <= 1'b0;
            end
            if (!ar && rsp.arready) begin
                ar = 1'b1;
                req.arvalid <= 1'b0;
            end
        end
        if (!got) chk(32'h0, 32'h1);
    endtask : axi_rd

    // Verdict and end of run
    task automatic wrap_up();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    // Hang guard at 12500 cycles, far beyond the few hundred cycles the run needs
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end

    // Main sequence
    initial begin
        tick(8);
        reset_n <= 1'b1;
        chk_ports(32'h0);
        axi_rd(MCB_OFF_SUPPLY_SEL, rd, rs);
        chk(rd, 32'h0);
        foreach (rows[i]) begin
            axi_wr(rows[i].off, rows[i].wdata, rows[i].strb, rs);
            chk(32'(rs), 32'(rows[i].resp));
            axi_rd(rows[i].off, rd, rs);
            chk(32'(rs), 32'(rows[i].resp));
            if (rows[i].dchk) chk(rd, rows[i].rdata);
        end
        tick(1);
        chk_ports(32'h0019_8100);
        // Core hand-over follows the converter, not the select bit
        core_rdy <= 1'b1;
        tick(6);
        axi_rd(MCB_OFF_SUPPLY_STATE, rd, rs);
        chk(rd, 32'h2);
        axi_wr(MCB_OFF_SUPPLY_SEL, 32'h0, 4'hF, rs);
        tick(6);
        chk(32'(core_act), 32'h1);
        core_rdy <= 1'b0;
        tick(6);
        chk(32'(core_act), 32'h0);
        // Memory converter ready without enable must not show as feeding
        mem_rdy <= 1'b1;
        tick(6);
        chk(32'(mem_act), 32'h0);
        axi_wr(MCB_OFF_SUPPLY_SEL, 32'h1, 4'hF, rs);
        tick(6);
        axi_rd(MCB_OFF_SUPPLY_STATE, rd, rs);
        chk(rd, 32'h1);
        // Segments cut only while sleeping
        deep_sleep <= 1'b1;
        tick(3);
        chk(32'(seg_off), 32'h81);
        deep_sleep <= 1'b0;
        tick(3);
        chk(32'(seg_off), 32'h0);
        // Second reset in mid-run clears every control
        mem_rdy <= 1'b0;
        reset_n <= 1'b0;
        tick(2);
        reset_n <= 1'b1;
        chk_ports(32'h0);
        axi_rd(MCB_OFF_REF_EN, rd, rs);
        chk(rd, 32'h0);
        axi_rd(MCB_OFF_SLEEP_PD, rd, rs);
        chk(rd, 32'h0);
        wrap_up();
    end
endmodule : testbench
